// ==== rtl/clsa_top.sv ====
// Control loop stall alarm with AXI4-Lite register slave
// Operation
// - Alarm when deviation exceeds level and does not shrink by band in time
// - Deviation within level: no detection, alarm held off
// - Asserted alarm clears when deviation shrinks by at least the band
// - Shrinking by less than the band within an interval still alarms
// - Detection time 0 to 9999 seconds; zero disables the function
// - Level defaults 8.0 degrees or 10.00 percent; range up to 999.9/99.99
// - Band defaults 3.0 degrees or 0.20 percent; range from zero
// - Result reaches an alarm output only when slot 1 type is 12
// - Type 12 accepted on slots 2 and 3 but gives no indication
// - No detection while the set-point ramp is running
// - No detection during auto-tuning or stop, nor in manual operation when the manual addition option is set
// - Slot 1 latch option holds the alarm once asserted
// - Auto-tuning end writes detection time, unless heating/cooling control
`timescale 1ns/1ps
module clsa_top #(
   parameter int unsigned TICK_CYCLES = clsa_pkg::TICK_CYCLES,
   parameter bit ANALOG_INPUT = 1'b0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic signed [15:0] sp_value,
   input wire logic signed [15:0] pv_value,
   input wire clsa_pkg::clsa_loop_t loop_in,
   output logic [2:0] stall_alarm,
   output logic irq
);
   localparam logic [13:0] LEVEL_DEF = ANALOG_INPUT ? clsa_pkg::ANA_LEVEL_DEF : clsa_pkg::TEMP_LEVEL_DEF;
   localparam logic [13:0] BAND_DEF = ANALOG_INPUT ? clsa_pkg::ANA_BAND_DEF : clsa_pkg::TEMP_BAND_DEF;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Bus state
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic wr_fire;
   logic [31:0] wmerged;

   // Configuration and interrupt state
   clsa_pkg::clsa_cfg_t cfg_q, cfg_d;
   logic [2:0] irq_st_q, irq_st_d, irq_en_q, irq_en_d;
   logic irq_q, irq_d;

   // Detection state
   clsa_pkg::clsa_state_t state_q, state_d;
   logic [16:0] ref_q, ref_d;
   logic [13:0] sec_q, sec_d;
   logic raw_q, raw_d, latch_q, latch_d;
   logic [2:0] alarm_q, alarm_d;
   logic signed [16:0] dev;
   logic [16:0] mag;
   logic outside, suppress, sec_tick, expire, reduced;
   logic [2:0] slot_hit;
   logic [11:0] types;

   assign s_axi_awready = !aw_have_q;
   assign s_axi_wready = !w_have_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign stall_alarm = alarm_q;
   assign irq = irq_q;

   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
   assign types = {cfg_q.type3, cfg_q.type2, cfg_q.type1};

   // Bus channels
   always_comb begin
      aw_have_d = aw_have_q;
      awaddr_d = awaddr_q;
      w_have_d = w_have_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (s_axi_awvalid && !aw_have_q) begin
         aw_have_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q) begin
         w_have_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (wr_fire) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = clsa_pkg::RESP_OKAY;
         if (awaddr_q > clsa_pkg::OFS_IRQ_ENABLE || awaddr_q == clsa_pkg::OFS_STATUS ||
             awaddr_q == clsa_pkg::OFS_IRQ_STATUS || awaddr_q[1:0] != 2'h0) begin
            bresp_d = clsa_pkg::RESP_SLVERR;
         end
      end
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && !rvalid_q) begin
         rvalid_d = 1'b1;
         rresp_d = clsa_pkg::RESP_OKAY;
         rdata_d = 32'h0000_0000;
         case (s_axi_araddr)
            clsa_pkg::OFS_DETECT_TIME: rdata_d[13:0] = cfg_q.loop_stall_detect_time;
            clsa_pkg::OFS_DEV_LEVEL: rdata_d[13:0] = cfg_q.stall_deviation_level;
            clsa_pkg::OFS_DEV_BAND: rdata_d[13:0] = cfg_q.band;
            clsa_pkg::OFS_ALARM_TYPE: rdata_d[11:0] = types;
            clsa_pkg::OFS_ALARM_CFG: begin
               rdata_d[clsa_pkg::CFG_LATCH] = cfg_q.latch;
               rdata_d[clsa_pkg::CFG_HEAT_COOL] = cfg_q.heat_cool;
               rdata_d[clsa_pkg::CFG_MANUAL_ADD] = cfg_q.auto_manual_select_addition;
            end
            clsa_pkg::OFS_STATUS: begin
               rdata_d[clsa_pkg::ST_ALARM] = raw_q;
               rdata_d[clsa_pkg::ST_TRACKING] = (state_q == clsa_pkg::CLSA_TRACK);
               rdata_d[clsa_pkg::ST_OUTSIDE] = outside;
               rdata_d[clsa_pkg::ST_LATCHED] = latch_q;
            end
            clsa_pkg::OFS_IRQ_STATUS: rdata_d[2:0] = irq_st_q;
            clsa_pkg::OFS_IRQ_CLEAR: rdata_d = 32'h0000_0000;
            clsa_pkg::OFS_IRQ_ENABLE: rdata_d[2:0] = irq_en_q;
            default: rresp_d = clsa_pkg::RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         w_have_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= clsa_pkg::RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= clsa_pkg::RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else begin
         aw_have_q <= aw_have_d;
         awaddr_q <= awaddr_d;
         w_have_q <= w_have_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   // Registers, writes and interrupt flags
   always_comb begin
      cfg_d = cfg_q;
      irq_en_d = irq_en_q;
      irq_st_d = irq_st_q;
      wmerged = 32'h0000_0000;
      if (wr_fire) begin
         case (awaddr_q)
            clsa_pkg::OFS_DETECT_TIME: begin
               wmerged = merge({18'h0_0000, cfg_q.loop_stall_detect_time}, wdata_q, wstrb_q);
               // Out-of-range values are dropped, old setting kept
               if (wmerged <= {18'h0_0000, clsa_pkg::PAR_MAX}) begin
                  cfg_d.loop_stall_detect_time = wmerged[13:0];
               end
            end
            clsa_pkg::OFS_DEV_LEVEL: begin
               wmerged = merge({18'h0_0000, cfg_q.stall_deviation_level}, wdata_q, wstrb_q);
               if (wmerged <= {18'h0_0000, clsa_pkg::PAR_MAX} &&
                   wmerged >= {18'h0_0000, clsa_pkg::LEVEL_MIN}) begin
                  cfg_d.stall_deviation_level = wmerged[13:0];
               end
            end
            clsa_pkg::OFS_DEV_BAND: begin
               wmerged = merge({18'h0_0000, cfg_q.band}, wdata_q, wstrb_q);
               if (wmerged <= {18'h0_0000, clsa_pkg::PAR_MAX}) begin
                  cfg_d.band = wmerged[13:0];
               end
            end
            clsa_pkg::OFS_ALARM_TYPE: begin
               // Any type code is stored on every slot
               wmerged = merge({20'h0_0000, types}, wdata_q, wstrb_q);
               cfg_d.type1 = wmerged[clsa_pkg::TYPE1_LSB +: 4];
               cfg_d.type2 = wmerged[clsa_pkg::TYPE2_LSB +: 4];
               cfg_d.type3 = wmerged[clsa_pkg::TYPE3_LSB +: 4];
            end
            clsa_pkg::OFS_ALARM_CFG: begin
               if (wstrb_q[0]) begin
                  cfg_d.latch = wdata_q[clsa_pkg::CFG_LATCH];
                  cfg_d.heat_cool = wdata_q[clsa_pkg::CFG_HEAT_COOL];
                  cfg_d.auto_manual_select_addition = wdata_q[clsa_pkg::CFG_MANUAL_ADD];
               end
            end
            clsa_pkg::OFS_IRQ_CLEAR: begin
               if (wstrb_q[0]) begin
                  irq_st_d = irq_st_q & ~wdata_q[2:0];
               end
            end
            clsa_pkg::OFS_IRQ_ENABLE: begin
               if (wstrb_q[0]) begin
                  irq_en_d = wdata_q[2:0];
               end
            end
            default: wmerged = 32'h0000_0000;
         endcase
      end
      // Auto-tuning result overrides a software write in the same cycle
      if (loop_in.autotune_done && !cfg_q.heat_cool) begin
         cfg_d.loop_stall_detect_time = (loop_in.autotune_time > clsa_pkg::PAR_MAX) ?
                                        clsa_pkg::PAR_MAX : loop_in.autotune_time;
         irq_st_d[clsa_pkg::IRQ_AUTOTIME] = 1'b1;
      end
      // Set after clear so a same-cycle event is never lost
      if (alarm_d[0] && !alarm_q[0]) begin
         irq_st_d[clsa_pkg::IRQ_RISE] = 1'b1;
      end
      if (!alarm_d[0] && alarm_q[0]) begin
         irq_st_d[clsa_pkg::IRQ_FALL] = 1'b1;
      end
      irq_d = |(irq_st_d & irq_en_d);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q.loop_stall_detect_time <= clsa_pkg::TIME_DEF;
         cfg_q.stall_deviation_level <= LEVEL_DEF;
         cfg_q.band <= BAND_DEF;
         cfg_q.type1 <= clsa_pkg::TYPE_NONE;
         cfg_q.type2 <= clsa_pkg::TYPE_NONE;
         cfg_q.type3 <= clsa_pkg::TYPE_NONE;
         cfg_q.latch <= 1'b0;
         cfg_q.heat_cool <= 1'b0;
         cfg_q.auto_manual_select_addition <= 1'b0;
         irq_en_q <= 3'h0;
         irq_st_q <= 3'h0;
         irq_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         irq_en_q <= irq_en_d;
         irq_st_q <= irq_st_d;
         irq_q <= irq_d;
      end
   end

   // Deviation magnitude; direction of the error does not matter
   assign dev = 17'(sp_value) - 17'(pv_value);
   assign mag = dev[16] ? 17'(-dev) : 17'(dev);
   assign outside = mag > {3'h0, cfg_q.stall_deviation_level};
   // Manual mode only counts when switching to it is enabled
   assign suppress = (cfg_q.loop_stall_detect_time == 14'h0000) ||
                     loop_in.ramp_active ||
                     loop_in.autotune_running || loop_in.control_stopped ||
                     (loop_in.manual_mode && cfg_q.auto_manual_select_addition);
   assign expire = sec_tick && ((sec_q + 14'h0001) >= cfg_q.loop_stall_detect_time);
   assign reduced = (ref_q >= mag) && ((ref_q - mag) >= {3'h0, cfg_q.band});

   clsa_tick #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .restart(state_q != clsa_pkg::CLSA_TRACK),
      .tick(sec_tick)
   );

   always_comb begin
      state_d = state_q;
      ref_d = ref_q;
      sec_d = sec_q;
      raw_d = raw_q;
      if (suppress) begin
         state_d = clsa_pkg::CLSA_IDLE;
         sec_d = 14'h0000;
         raw_d = 1'b0;
      end else if (!outside) begin
         state_d = clsa_pkg::CLSA_INBAND;
         sec_d = 14'h0000;
         raw_d = 1'b0;
      end else begin
         case (state_q)
            clsa_pkg::CLSA_TRACK: begin
               if (expire) begin
                  // Reduced by band clears, anything less sets
                  raw_d = !reduced;
                  ref_d = mag;
                  sec_d = 14'h0000;
               end else if (sec_tick) begin
                  sec_d = sec_q + 14'h0001;
               end
            end
            default: begin
               state_d = clsa_pkg::CLSA_TRACK;
               ref_d = mag;
               sec_d = 14'h0000;
            end
         endcase
      end
      latch_d = latch_q;
      if (!cfg_q.latch || cfg_q.type1 != clsa_pkg::TYPE_STALL) begin
         latch_d = 1'b0;
      end else if (raw_q) begin
         latch_d = 1'b1;
      end
      for (int s = 0; s < 3; s++) begin
         alarm_d[s] = slot_hit[s] && (raw_q || latch_q);
      end
   end

   // Only slot 1 carries the result; type 12 elsewhere stays silent
   for (genvar g = 0; g < 3; g++) begin : g_slot
      assign slot_hit[g] = (g == 0) && (types[g*4 +: 4] == clsa_pkg::TYPE_STALL);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= clsa_pkg::CLSA_IDLE;
         ref_q <= 17'h0_0000;
         sec_q <= 14'h0000;
         raw_q <= 1'b0;
         latch_q <= 1'b0;
         alarm_q <= 3'h0;
      end else begin
         state_q <= state_d;
         ref_q <= ref_d;
         sec_q <= sec_d;
         raw_q <= raw_d;
         latch_q <= latch_d;
         alarm_q <= alarm_d;
      end
   end
endmodule

// ==== rtl/clsa_pkg.sv ====
// Constants and types for the control loop stall alarm
package clsa_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned TICK_PERIOD_S = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;

   localparam int VAL_W = 16;
   localparam int PAR_W = 14;
   localparam int ADDR_W = 8;

   // Raw units: tenths of a degree, or hundredths of a percent
   localparam logic [13:0] PAR_MAX = 14'h270F;
   localparam logic [13:0] LEVEL_MIN = 14'h0001;
   localparam logic [13:0] TIME_DEF = 14'h0000;
   localparam logic [13:0] TEMP_LEVEL_DEF = 14'h0050;
   localparam logic [13:0] TEMP_BAND_DEF = 14'h001E;
   localparam logic [13:0] ANA_LEVEL_DEF = 14'h03E8;
   localparam logic [13:0] ANA_BAND_DEF = 14'h0014;
   localparam logic [3:0] TYPE_STALL = 4'hC;
   localparam logic [3:0] TYPE_NONE = 4'h0;

   localparam logic [7:0] OFS_DETECT_TIME = 8'h00;
   localparam logic [7:0] OFS_DEV_LEVEL = 8'h04;
   localparam logic [7:0] OFS_DEV_BAND = 8'h08;
   localparam logic [7:0] OFS_ALARM_TYPE = 8'h0C;
   localparam logic [7:0] OFS_ALARM_CFG = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1C;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;

   // Field positions
   localparam int TYPE1_LSB = 0;
   localparam int TYPE2_LSB = 4;
   localparam int TYPE3_LSB = 8;
   localparam int CFG_LATCH = 0;
   localparam int CFG_HEAT_COOL = 1;
   localparam int CFG_MANUAL_ADD = 2;
   localparam int ST_ALARM = 0;
   localparam int ST_TRACKING = 1;
   localparam int ST_OUTSIDE = 2;
   localparam int ST_LATCHED = 3;
   localparam int IRQ_RISE = 0;
   localparam int IRQ_FALL = 1;
   localparam int IRQ_AUTOTIME = 2;
   localparam int IRQ_W = 3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [13:0] loop_stall_detect_time;
      logic [13:0] stall_deviation_level;
      logic [13:0] band;
      logic [3:0] type1;
      logic [3:0] type2;
      logic [3:0] type3;
      logic latch;
      logic heat_cool;
      logic auto_manual_select_addition;
   } clsa_cfg_t;

   typedef struct packed {
      logic ramp_active;
      logic autotune_running;
      logic autotune_done;
      logic [13:0] autotune_time;
      logic manual_mode;
      logic control_stopped;
   } clsa_loop_t;

   typedef enum logic [2:0] {
      CLSA_IDLE = 3'h1,
      CLSA_INBAND = 3'h2,
      CLSA_TRACK = 3'h4
   } clsa_state_t;
endpackage

// ==== rtl/clsa_tick.sv ====
// Seconds time base: one-cycle enable pulse, restartable
`timescale 1ns/1ps
module clsa_tick #(
   parameter int unsigned CYCLES = clsa_pkg::TICK_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic restart,
   output logic tick
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic tick_q;
   logic tick_d;

   always_comb begin
      cnt_d = cnt_q + CW'(1);
      tick_d = 1'b0;
      if (restart) begin
         cnt_d = '0;
      end else if (cnt_q == LAST) begin
         cnt_d = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule

// ==== verif/clsa_loop_model.sv ====
// Process loop model: set point, creeping process value, mode flags
`timescale 1ns/1ps
module clsa_loop_model (
   input wire logic aclk,
   input wire logic signed [15:0] sp_cmd,
   input wire logic pv_load,
   input wire logic signed [15:0] pv_init,
   input wire logic signed [15:0] pv_step,
   input wire clsa_pkg::clsa_loop_t mode_cmd,
   output logic signed [15:0] sp_value,
   output logic signed [15:0] pv_value,
   output clsa_pkg::clsa_loop_t loop_in
);
   // Sensor creeps a step per cycle, never past the set point
   always_ff @(posedge aclk) begin
      sp_value <= sp_cmd;
      loop_in <= mode_cmd;
      if (pv_load) begin
         pv_value <= pv_init;
      end else if (pv_value + pv_step <= sp_cmd) begin
         pv_value <= pv_value + pv_step;
      end
   end
endmodule

// ==== verif/clsa_asserts.sv ====
// Port checks for the control loop stall alarm
`timescale 1ns/1ps
module clsa_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic signed [15:0] sp_value,
   input wire logic signed [15:0] pv_value,
   input wire clsa_pkg::clsa_loop_t loop_in,
   input wire logic [2:0] stall_alarm,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Raw result lands one edge before the output, hence depth 2
   property p_slots; stall_alarm[2:1] == 2'b00; endproperty
   property p_ramp; $rose(stall_alarm[0]) |-> !$past(loop_in.ramp_active, 2); endproperty
   property p_hold;
      $rose(stall_alarm[0]) |-> !$past(loop_in.autotune_running, 2) && !$past(loop_in.control_stopped, 2);
   endproperty
   property p_dev; $rose(stall_alarm[0]) |-> $past(sp_value, 2) != $past(pv_value, 2); endproperty
   property p_wlat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
   endproperty
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_slots: assert property (p_slots) else $error("slot 2 or 3 alarm raised");
   a_ramp: assert property (p_ramp) else $error("alarm rose during ramp");
   a_hold: assert property (p_hold) else $error("alarm rose while tuning or stopped");
   a_dev: assert property (p_dev) else $error("alarm rose with zero deviation");
   a_wlat: assert property (p_wlat) else $error("write response late");
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   a_rlat: assert property (p_rlat) else $error("read data late");
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   a_arblk: assert property (p_arblk) else $error("read address taken while busy");
   c_rise: cover property ($rose(stall_alarm[0]));
   c_fall: cover property ($fell(stall_alarm[0]));
   c_irq: cover property ($rose(irq));
endmodule
bind clsa_top clsa_asserts i_asserts (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .sp_value, .pv_value, .loop_in, .stall_alarm, .irq);

// ==== verif/control_loop_stall_alarm_test.sv ====
// Self-checking bench for the control loop stall alarm
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; $display("BAD %0t %h %h", $time, g, e); end end
module control_loop_stall_alarm_test;
   logic aclk = 1'b0, aresetn = 1'b0, pv_load = 1'b1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [2:0] stall_alarm;
   logic signed [15:0] sp_cmd = 16'h07D0, pv_init = 16'h0000, pv_step = 16'h0000, sp_value, pv_value;
   clsa_pkg::clsa_loop_t mode_cmd = '0, loop_in;
   int bad_count = 0, checked = 0, cyc = 0;
   // Short second so an interval is 8 cycles with a detection time of 2
   clsa_top #(.TICK_CYCLES(4), .ANALOG_INPUT(1'b0)) i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp, .sp_value, .pv_value, .loop_in, .stall_alarm, .irq);
   clsa_loop_model i_loop (.aclk, .sp_cmd, .pv_load, .pv_init, .pv_step, .mode_cmd, .sp_value, .pv_value, .loop_in);
   always #12.5 aclk = ~aclk;
   task automatic final_report();
      if (bad_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         bad_count++;
         final_report();
      end
   end
   // Leading edge wait keeps ready lowering and raising in separate steps
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ah = 1'b0;
      logic wh = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!ah || !wh) begin
         @(posedge aclk);
         if (!ah && s_axi_awready) begin
            ah = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wh && s_axi_wready) begin
            wh = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic set_pv(input logic signed [15:0] v);
      pv_init <= v;
      pv_load <= 1'b1;
      @(posedge aclk);
      pv_load <= 1'b0;
   endtask
   task automatic t_regs();
      rd_reg(8'h00);
      `CHK(rd, 32'h0000_0000)
      rd_reg(8'h08);
      `CHK(rd, 32'h0000_001E)
      wr(8'h04, 32'h0000_0000);
      rd_reg(8'h04);
      `CHK(rd, 32'h0000_0050)
      rd_reg(8'h40);
      `CHK(rs, clsa_pkg::RESP_SLVERR)
      wr(8'h14, 32'h0000_0001);
      `CHK(rs, clsa_pkg::RESP_SLVERR)
   endtask
   task automatic t_stall();
      wr(8'h20, 32'h0000_0007);
      wr(8'h0C, 32'h0000_0CC0);
      wr(8'h00, 32'h0000_0002);
      repeat (30) @(posedge aclk);
      `CHK(stall_alarm, 3'b000)
      wr(8'h0C, 32'h0000_0CCC);
      repeat (30) @(posedge aclk);
      `CHK(stall_alarm, 3'b001)
      `CHK(irq, 1'b1)
      wr(8'h1C, 32'h0000_0007);
      repeat (2) @(posedge aclk);
      `CHK(irq, 1'b0)
      pv_step <= 16'h0005;
      repeat (30) @(posedge aclk);
      `CHK(stall_alarm, 3'b000)
      rd_reg(8'h18);
      `CHK(rd[1:0], 2'b10)
      pv_step <= 16'h0001;
      repeat (30) @(posedge aclk);
      `CHK(stall_alarm, 3'b001)
   endtask
   task automatic t_suppress();
      pv_step <= 16'h0000;
      wr(8'h10, 32'h0000_0004);
      for (int i = 0; i < 4; i++) begin
         mode_cmd <= '{ramp_active: i == 0, autotune_running: i == 1, manual_mode: i == 2,
            control_stopped: i == 3, default: '0};
         repeat (30) @(posedge aclk);
         `CHK(stall_alarm, 3'b000)
         mode_cmd <= '0;
         repeat (30) @(posedge aclk);
         `CHK(stall_alarm, 3'b001)
      end
   endtask
   task automatic t_latch();
      wr(8'h10, 32'h0000_0005);
      set_pv(16'h07C6);
      repeat (30) @(posedge aclk);
      `CHK(stall_alarm, 3'b001)
      wr(8'h10, 32'h0000_0004);
      repeat (4) @(posedge aclk);
      `CHK(stall_alarm, 3'b000)
      rd_reg(8'h14);
      `CHK(rd[2], 1'b0)
   endtask
   task automatic t_time();
      set_pv(16'h0000);
      wr(8'h00, 32'h0000_0000);
      repeat (30) @(posedge aclk);
      `CHK(stall_alarm, 3'b000)
      wr(8'h00, 32'h0000_2710);
      rd_reg(8'h00);
      `CHK(rd, 32'h0000_0000)
      wr(8'h00, 32'h0000_270F);
      rd_reg(8'h00);
      `CHK(rd, 32'h0000_270F)
   endtask
   task automatic t_autotune();
      mode_cmd <= '{autotune_done: 1'b1, autotune_time: 14'h0005, default: '0};
      @(posedge aclk);
      mode_cmd <= '0;
      rd_reg(8'h00);
      `CHK(rd, 32'h0000_0005)
      rd_reg(8'h18);
      `CHK(rd[2], 1'b1)
      wr(8'h10, 32'h0000_0002);
      mode_cmd <= '{autotune_done: 1'b1, autotune_time: 14'h0007, default: '0};
      @(posedge aclk);
      mode_cmd <= '0;
      rd_reg(8'h00);
      `CHK(rd, 32'h0000_0005)
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      pv_load <= 1'b0;
      t_regs();
      t_stall();
      t_suppress();
      t_latch();
      t_time();
      t_autotune();
      final_report();
   end
endmodule
